/* File: core/wct_pkg.sv */
/*
 * Shared constants and types for the window comparator threshold register bank:
 * register indices, reset values, field positions and carrier structs.
 * Assumes a single 100 MHz clock domain and an APB master with 32-bit data.
 */
`default_nettype none

package wct_pkg;

    // Channels held by this bank, and the channel number of the first one
    localparam int WCT_NCH = 3;
    localparam int WCT_CH_BASE = 4;
    localparam int WCT_CODE_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] WCT_IDX_CH4_LOWLIM_NIBBLE_AND_DEBOUNCE = 8'h32;
    localparam logic [7:0] WCT_IDX_CH4_LOWLIM_UPPER_BYTE = 8'h33;
    localparam logic [7:0] WCT_IDX_CH5_HIGHLIM_NIBBLE_AND_DEADBAND = 8'h34;
    localparam logic [7:0] WCT_IDX_CH5_HIGHLIM_UPPER_BYTE = 8'h35;
    localparam logic [7:0] WCT_IDX_CH5_LOWLIM_NIBBLE_AND_DEBOUNCE = 8'h36;
    localparam logic [7:0] WCT_IDX_CH5_LOWLIM_UPPER_BYTE = 8'h37;
    localparam logic [7:0] WCT_IDX_CH6_HIGHLIM_NIBBLE_AND_DEADBAND = 8'h38;
    localparam logic [7:0] WCT_IDX_CH6_HIGHLIM_UPPER_BYTE = 8'h39;
    localparam logic [7:0] WCT_IDX_CH6_LOWLIM_NIBBLE_AND_DEBOUNCE = 8'h3A;
    localparam logic [7:0] WCT_IDX_EVENT_STATUS = 8'h40;
    localparam logic [7:0] WCT_IDX_EVENT_MASK = 8'h41;
    localparam int WCT_NREG = 9;

    // Values after reset
    localparam logic [7:0] WCT_RST_NIBBLE_AND_DEADBAND = 8'hF0;
    localparam logic [7:0] WCT_RST_HIGHLIM_UPPER_BYTE = 8'hFF;
    localparam logic [7:0] WCT_RST_NIBBLE_AND_DEBOUNCE = 8'h00;
    localparam logic [7:0] WCT_RST_LOWLIM_UPPER_BYTE = 8'h00;
    localparam logic [5:0] WCT_RST_EVENT_STATUS = 6'h00;
    localparam logic [5:0] WCT_RST_EVENT_MASK = 6'h00;

    // Field positions
    localparam int WCT_NIBBLE_MSB = 7;
    localparam int WCT_NIBBLE_LSB = 4;
    localparam int WCT_LOWFIELD_MSB = 3;
    localparam int WCT_LOWFIELD_LSB = 0;
    localparam int WCT_DEADBAND_SHIFT = 3;
    localparam int WCT_DEADBAND_W = 7;
    localparam int WCT_EVT_HIGH_LSB = 0;
    localparam int WCT_EVT_LOW_LSB = 3;
    localparam int WCT_EVT_W = 6;

    typedef enum logic [0:0] {
        WCT_ARMED = 1'b0,
        WCT_TRIPPED = 1'b1
    } wct_trip_t;

    typedef struct packed {
        logic [WCT_CODE_W-1:0] high_thr;
        logic [WCT_CODE_W-1:0] low_thr;
        logic [WCT_DEADBAND_W-1:0] deadband;
        logic [3:0] count;
    } wct_cfg_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [WCT_CODE_W-1:0] code;
    } wct_sample_t;

endpackage : wct_pkg

`default_nettype wire

/* File: core/wct_regs.sv */
/*
 * Threshold, deadband and debounce registers for channels 4 to 6 of a digital
 * window comparator, an APB slave to reach them, and the per-channel
 * consecutive-sample event detection with a sticky, maskable interrupt.
 * Assumes samples arrive synchronous to I_CLOCK, one per valid strobe; the
 * channel 4 high limit and channel 6 low upper byte live in a neighbouring bank.
 */
// Added by the designer: the APB register port.
`default_nettype none

// What this block does
// - Low-limit upper byte compares top eight bits
// - High-limit upper byte aligned to code MSBs
// - Low-limit nibble in debounce register bits 7:4
// - High-limit nibble in deadband register bits 7:4
// - Deadband nibble shifted left three positions
// - Same deadband applied to both limits
// - Event after n+1 consecutive crossing samples
// - High-limit upper byte resets to all ones
// - Deadband register resets to 0xF0
// - Low-limit and debounce registers reset to zero
// - Four consecutive addresses per channel, fixed order
module wct_regs #(
    parameter int CHAN_W = 3
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    // Conversion results
    input wire wct_pkg::wct_sample_t I_SAMPLE,
    // Limits and deadband held by the neighbouring bank
    input wire logic [11:0] I_CH4_HIGH_THR,
    input wire logic [3:0] I_CH4_DEADBAND_NIBBLE,
    input wire logic [7:0] I_CH6_LOWLIM_UPPER_BYTE,
    // Comparator settings and events
    output wct_pkg::wct_cfg_t O_CFG_CH4,
    output wct_pkg::wct_cfg_t O_CFG_CH5,
    output wct_pkg::wct_cfg_t O_CFG_CH6,
    output logic [2:0] O_EVENT_HIGH,
    output logic [2:0] O_EVENT_LOW,
    output logic O_IRQ
);

    // Channel numbers 4 to 6 need three bits
    if (CHAN_W < 3) begin : g_chan_w_check
        $error("CHAN_W must be at least 3");
    end

    function automatic logic [7:0] reset_value(input logic [7:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            wct_pkg::WCT_IDX_CH5_HIGHLIM_NIBBLE_AND_DEADBAND,
            wct_pkg::WCT_IDX_CH6_HIGHLIM_NIBBLE_AND_DEADBAND: begin
                r = wct_pkg::WCT_RST_NIBBLE_AND_DEADBAND;
            end
            wct_pkg::WCT_IDX_CH5_HIGHLIM_UPPER_BYTE,
            wct_pkg::WCT_IDX_CH6_HIGHLIM_UPPER_BYTE: begin
                r = wct_pkg::WCT_RST_HIGHLIM_UPPER_BYTE;
            end
            wct_pkg::WCT_IDX_CH4_LOWLIM_UPPER_BYTE,
            wct_pkg::WCT_IDX_CH5_LOWLIM_UPPER_BYTE: begin
                r = wct_pkg::WCT_RST_LOWLIM_UPPER_BYTE;
            end
            default: begin
                r = wct_pkg::WCT_RST_NIBBLE_AND_DEBOUNCE;
            end
        endcase
        return r;
    endfunction : reset_value

    // Twelve-bit limit from upper byte and lower nibble
    function automatic logic [11:0] join_limit(input logic [7:0] upper, input logic [7:0] nib_reg);
        return {upper, nib_reg[wct_pkg::WCT_NIBBLE_MSB:wct_pkg::WCT_NIBBLE_LSB]};
    endfunction : join_limit

    function automatic logic [6:0] deadband_of(input logic [3:0] nib);
        return {nib, 3'h0};
    endfunction : deadband_of

    // Saturating so a wide deadband near the rails cannot wrap
    function automatic logic [11:0] sat_sub(input logic [11:0] a, input logic [6:0] b);
        logic [12:0] t;
        t = {1'b0, a} - {6'h00, b};
        return t[12] ? 12'h000 : t[11:0];
    endfunction : sat_sub

    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [6:0] b);
        logic [12:0] t;
        t = {1'b0, a} + {6'h00, b};
        return t[12] ? 12'hFFF : t[11:0];
    endfunction : sat_add

    function automatic logic idx_in_bank(input logic [7:0] idx);
        return (idx >= wct_pkg::WCT_IDX_CH4_LOWLIM_NIBBLE_AND_DEBOUNCE) &&
               (idx <= wct_pkg::WCT_IDX_CH6_LOWLIM_NIBBLE_AND_DEBOUNCE);
    endfunction : idx_in_bank

    // Register file state
    logic [7:0] regs_q [wct_pkg::WCT_NREG];
    logic [7:0] regs_d [wct_pkg::WCT_NREG];
    logic [5:0] status_q;
    logic [5:0] status_d;
    logic [5:0] mask_q;
    logic [5:0] mask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;

    // Comparator state
    wct_pkg::wct_cfg_t cfg_q [wct_pkg::WCT_NCH];
    wct_pkg::wct_cfg_t cfg_d [wct_pkg::WCT_NCH];
    wct_pkg::wct_trip_t hi_st_q [wct_pkg::WCT_NCH];
    wct_pkg::wct_trip_t hi_st_d [wct_pkg::WCT_NCH];
    wct_pkg::wct_trip_t lo_st_q [wct_pkg::WCT_NCH];
    wct_pkg::wct_trip_t lo_st_d [wct_pkg::WCT_NCH];
    logic [4:0] hi_cnt_q [wct_pkg::WCT_NCH];
    logic [4:0] hi_cnt_d [wct_pkg::WCT_NCH];
    logic [4:0] lo_cnt_q [wct_pkg::WCT_NCH];
    logic [4:0] lo_cnt_d [wct_pkg::WCT_NCH];
    logic [5:0] evt_set;

    logic [7:0] bus_idx;
    logic bus_aligned;
    logic bus_mapped;
    logic setup_ph;
    logic wr_acc;
    logic [7:0] bank_off;
    logic [CHAN_W-1:0] smp_chan;

    assign bus_idx = I_PADDR[9:2];
    assign bus_aligned = (I_PADDR[1:0] == 2'h0) && (I_PADDR[11:10] == 2'h0);
    assign bus_mapped = bus_aligned && (idx_in_bank(bus_idx) ||
                        (bus_idx == wct_pkg::WCT_IDX_EVENT_STATUS) ||
                        (bus_idx == wct_pkg::WCT_IDX_EVENT_MASK));
    assign setup_ph = I_PSEL && !I_PENABLE;
    assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && bus_mapped && I_PSTRB[0];
    assign bank_off = bus_idx - wct_pkg::WCT_IDX_CH4_LOWLIM_NIBBLE_AND_DEBOUNCE;
    assign smp_chan = CHAN_W'(I_SAMPLE.chan);

    // APB: zero wait states, read data captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        err_d = err_q;
        if (setup_ph) begin
            err_d = !bus_mapped;
            prdata_d = 32'h0000_0000;
            if (bus_mapped && !I_PWRITE) begin
                if (idx_in_bank(bus_idx)) begin
                    prdata_d = {24'h00_0000, regs_q[bank_off[3:0]]};
                end else if (bus_idx == wct_pkg::WCT_IDX_EVENT_STATUS) begin
                    prdata_d = {26'h000_0000, status_q};
                end else begin
                    prdata_d = {26'h000_0000, mask_q};
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < wct_pkg::WCT_NREG; i++) begin
            regs_d[i] = regs_q[i];
        end
        mask_d = mask_q;
        if (wr_acc && idx_in_bank(bus_idx)) begin
            regs_d[bank_off[3:0]] = I_PWDATA[7:0];
        end
        if (wr_acc && (bus_idx == wct_pkg::WCT_IDX_EVENT_MASK)) begin
            mask_d = I_PWDATA[5:0];
        end
    end

    // Hardware set wins over a write-one-to-clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr_acc && (bus_idx == wct_pkg::WCT_IDX_EVENT_STATUS)) begin
            status_d = status_q & ~I_PWDATA[5:0];
        end
        status_d = status_d | evt_set;
    end

    // Settings as seen by the comparator
    always_comb begin
        cfg_d[0].high_thr = I_CH4_HIGH_THR;
        cfg_d[0].low_thr = join_limit(regs_q[1], regs_q[0]);
        cfg_d[0].deadband = deadband_of(I_CH4_DEADBAND_NIBBLE);
        cfg_d[0].count = regs_q[0][wct_pkg::WCT_LOWFIELD_MSB:wct_pkg::WCT_LOWFIELD_LSB];
        cfg_d[1].high_thr = join_limit(regs_q[3], regs_q[2]);
        cfg_d[1].low_thr = join_limit(regs_q[5], regs_q[4]);
        cfg_d[1].deadband = deadband_of(
            regs_q[2][wct_pkg::WCT_LOWFIELD_MSB:wct_pkg::WCT_LOWFIELD_LSB]);
        cfg_d[1].count = regs_q[4][wct_pkg::WCT_LOWFIELD_MSB:wct_pkg::WCT_LOWFIELD_LSB];
        cfg_d[2].high_thr = join_limit(regs_q[7], regs_q[6]);
        cfg_d[2].low_thr = join_limit(I_CH6_LOWLIM_UPPER_BYTE, regs_q[8]);
        cfg_d[2].deadband = deadband_of(
            regs_q[6][wct_pkg::WCT_LOWFIELD_MSB:wct_pkg::WCT_LOWFIELD_LSB]);
        cfg_d[2].count = regs_q[8][wct_pkg::WCT_LOWFIELD_MSB:wct_pkg::WCT_LOWFIELD_LSB];
    end

    // Debounce and deadband per channel; a tripped side re-arms only
    // once the code has moved back past the limit by the deadband
    always_comb begin
        logic hit;
        logic [4:0] need;
        hit = 1'b0;
        need = 5'h00;
        evt_set = 6'h00;
        for (int c = 0; c < wct_pkg::WCT_NCH; c++) begin
            hi_st_d[c] = hi_st_q[c];
            lo_st_d[c] = lo_st_q[c];
            hi_cnt_d[c] = hi_cnt_q[c];
            lo_cnt_d[c] = lo_cnt_q[c];
            need = {1'b0, cfg_q[c].count};
            if (I_SAMPLE.valid && (smp_chan == CHAN_W'(wct_pkg::WCT_CH_BASE + c))) begin
                case (hi_st_q[c])
                    wct_pkg::WCT_ARMED: begin
                        hit = I_SAMPLE.code > cfg_q[c].high_thr;
                        if (!hit) begin
                            hi_cnt_d[c] = 5'h00;
                        end else if (hi_cnt_q[c] == need) begin
                            evt_set[wct_pkg::WCT_EVT_HIGH_LSB + c] = 1'b1;
                            hi_st_d[c] = wct_pkg::WCT_TRIPPED;
                            hi_cnt_d[c] = 5'h00;
                        end else begin
                            hi_cnt_d[c] = hi_cnt_q[c] + 5'h01;
                        end
                    end
                    wct_pkg::WCT_TRIPPED: begin
                        if (I_SAMPLE.code < sat_sub(cfg_q[c].high_thr, cfg_q[c].deadband)) begin
                            hi_st_d[c] = wct_pkg::WCT_ARMED;
                        end
                    end
                    default: begin
                        hi_st_d[c] = wct_pkg::WCT_ARMED;
                    end
                endcase
                case (lo_st_q[c])
                    wct_pkg::WCT_ARMED: begin
                        hit = I_SAMPLE.code < cfg_q[c].low_thr;
                        if (!hit) begin
                            lo_cnt_d[c] = 5'h00;
                        end else if (lo_cnt_q[c] == need) begin
                            evt_set[wct_pkg::WCT_EVT_LOW_LSB + c] = 1'b1;
                            lo_st_d[c] = wct_pkg::WCT_TRIPPED;
                            lo_cnt_d[c] = 5'h00;
                        end else begin
                            lo_cnt_d[c] = lo_cnt_q[c] + 5'h01;
                        end
                    end
                    wct_pkg::WCT_TRIPPED: begin
                        if (I_SAMPLE.code > sat_add(cfg_q[c].low_thr, cfg_q[c].deadband)) begin
                            lo_st_d[c] = wct_pkg::WCT_ARMED;
                        end
                    end
                    default: begin
                        lo_st_d[c] = wct_pkg::WCT_ARMED;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            for (int i = 0; i < wct_pkg::WCT_NREG; i++) begin
                regs_q[i] <= reset_value(8'(i) + wct_pkg::WCT_IDX_CH4_LOWLIM_NIBBLE_AND_DEBOUNCE);
            end
            status_q <= wct_pkg::WCT_RST_EVENT_STATUS;
            mask_q <= wct_pkg::WCT_RST_EVENT_MASK;
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            for (int i = 0; i < wct_pkg::WCT_NREG; i++) begin
                regs_q[i] <= regs_d[i];
            end
            status_q <= status_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            for (int c = 0; c < wct_pkg::WCT_NCH; c++) begin
                cfg_q[c] <= '0;
                hi_st_q[c] <= wct_pkg::WCT_ARMED;
                lo_st_q[c] <= wct_pkg::WCT_ARMED;
                hi_cnt_q[c] <= 5'h00;
                lo_cnt_q[c] <= 5'h00;
            end
        end else begin
            for (int c = 0; c < wct_pkg::WCT_NCH; c++) begin
                cfg_q[c] <= cfg_d[c];
                hi_st_q[c] <= hi_st_d[c];
                lo_st_q[c] <= lo_st_d[c];
                hi_cnt_q[c] <= hi_cnt_d[c];
                lo_cnt_q[c] <= lo_cnt_d[c];
            end
        end
    end

    assign O_PREADY = 1'b1;
    assign O_PRDATA = prdata_q;
    assign O_PSLVERR = I_PSEL && I_PENABLE && err_q;
    assign O_CFG_CH4 = cfg_q[0];
    assign O_CFG_CH5 = cfg_q[1];
    assign O_CFG_CH6 = cfg_q[2];
    assign O_EVENT_HIGH = status_q[wct_pkg::WCT_EVT_HIGH_LSB +: 3];
    assign O_EVENT_LOW = status_q[wct_pkg::WCT_EVT_LOW_LSB +: 3];
    assign O_IRQ = |(status_q & mask_q);

endmodule : wct_regs

`default_nettype wire

/* File: dv/wct_apb_host.sv */
/*
 * APB host model; the bench calls its xfer task.
 * Assumes the slave answers on pready; the bench timeout ends a hang.
 */
`default_nettype none

module wct_apb_host (
    // Clock
    input wire logic i_clk,
    // Request
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata,
    output logic [3:0] o_pstrb,
    // Answer
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0;
        o_pstrb = 4'h0;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        o_pstrb <= 4'hF;
        @(posedge i_clk);
        o_penable <= 1'b1;
        // Request held until pready is seen at an edge
        do @(posedge i_clk); while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Idle bus shows inverted address and data, so a stale decode shows up
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask : xfer
endmodule : wct_apb_host

`default_nettype wire

/* File: dv/wct_regs_asserts.sv */
/*
 * Port checker for wct_regs, bound to every instance.
 * Assumes one clock domain and the APB host asserting 4'hF strobes.
 */
`default_nettype none

module wct_regs_asserts (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // APB
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic O_PSLVERR,
    // Samples and results
    input wire wct_pkg::wct_sample_t I_SAMPLE,
    input wire wct_pkg::wct_cfg_t O_CFG_CH4,
    input wire wct_pkg::wct_cfg_t O_CFG_CH5,
    input wire logic [2:0] O_EVENT_HIGH,
    input wire logic [2:0] O_EVENT_LOW,
    input wire logic O_IRQ
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    chk_rst_limits: assert property ($fell(I_RST) |-> ##[1:3] (O_CFG_CH5.high_thr == 12'hFFF
        && O_CFG_CH5.low_thr == 12'h000 && O_CFG_CH5.count == 4'h0))
        else $error("limits wrong after reset");
    chk_deadband_zero: assert property (O_CFG_CH5.deadband[2:0] == 3'h0
        && O_CFG_CH4.deadband[2:0] == 3'h0) else $error("deadband low bits set");
    chk_cfg_follow: assert property (I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0]
        && I_PADDR == 12'h0D4 |-> ##2 O_CFG_CH5.high_thr[11:4] == $past(I_PWDATA[7:0], 2))
        else $error("high limit not updated");
    chk_high_cross: assert property ($rose(O_EVENT_HIGH[1])
        |-> $past(I_SAMPLE.code) > $past(O_CFG_CH5.high_thr)) else $error("high event bad");
    chk_low_cross: assert property ($rose(O_EVENT_LOW[0])
        |-> $past(I_SAMPLE.code) < $past(O_CFG_CH4.low_thr)) else $error("low event bad");
    chk_event_chan: assert property ($rose(O_EVENT_HIGH[1])
        |-> $past(I_SAMPLE.valid) && $past(I_SAMPLE.chan) == 3'h5) else $error("no sample");
    chk_debounce_one: assert property ($rose(O_EVENT_HIGH[1]) && O_CFG_CH5.count == 4'h1
        |-> $past(I_SAMPLE.valid, 2)) else $error("event too early");
    chk_bad_addr: assert property (I_PSEL && I_PENABLE && I_PADDR[1:0] != 2'h0
        |-> O_PSLVERR) else $error("misaligned access accepted");
    chk_irq_quiet: assert property (!(|{O_EVENT_HIGH, O_EVENT_LOW}) |-> !O_IRQ)
        else $error("interrupt without event");
    chk_irq_cause: assert property ($rose(O_IRQ) |-> (|(O_EVENT_HIGH & ~$past(O_EVENT_HIGH)))
        || (|(O_EVENT_LOW & ~$past(O_EVENT_LOW))) || ($past(I_PSEL) && $past(I_PENABLE)
        && $past(I_PWRITE) && $past(I_PADDR) == 12'h104)) else $error("interrupt rose alone");

    cover property ($rose(O_EVENT_HIGH[1]));
    cover property ($rose(O_EVENT_LOW[0]));
    cover property ($rose(O_IRQ));
endmodule : wct_regs_asserts

bind wct_regs wct_regs_asserts u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_PSTRB(I_PSTRB), .O_PSLVERR(O_PSLVERR), .I_SAMPLE(I_SAMPLE), .O_CFG_CH4(O_CFG_CH4),
    .O_CFG_CH5(O_CFG_CH5), .O_EVENT_HIGH(O_EVENT_HIGH), .O_EVENT_LOW(O_EVENT_LOW),
    .O_IRQ(O_IRQ));

`default_nettype wire

/* File: dv/window_comparator_threshold_regs_tb_top.sv */
/*
 * Bench for wct_regs: APB host, sample driver and reference model.
 * Assumes the checker binds itself to wct_regs.
 */
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, x); end end

module window_comparator_threshold_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, pen, pwr, prdy, perr, irq, e;
    logic [11:0] paddr, ch4_hi;
    logic [31:0] pwd, prd, rd;
    logic [3:0] pstrb, ch4_db;
    logic [7:0] ch6_lo;
    logic [2:0] ev_hi, ev_lo;
    wct_pkg::wct_sample_t smp;
    wct_pkg::wct_cfg_t cfg [3];
    int n_mismatch, total_checks, cyc, seed, stat;
    int mdl [int];
    int wq [$] = '{'h33, 'h80, 'h32, 0, 'h35, 'h80, 'h34, 0, 'h36, 1, 'h39, 'h80, 'h38, 0,
                   'h3A, 2};

    wct_regs DUT (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwd), .I_PSTRB(pstrb), .O_PREADY(prdy), .O_PRDATA(prd),
        .O_PSLVERR(perr), .I_SAMPLE(smp), .I_CH4_HIGH_THR(ch4_hi),
        .I_CH4_DEADBAND_NIBBLE(ch4_db), .I_CH6_LOWLIM_UPPER_BYTE(ch6_lo),
        .O_CFG_CH4(cfg[0]), .O_CFG_CH5(cfg[1]), .O_CFG_CH6(cfg[2]), .O_EVENT_HIGH(ev_hi),
        .O_EVENT_LOW(ev_lo), .O_IRQ(irq));
    wct_apb_host u_host (.i_clk(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
        .o_paddr(paddr), .o_pwdata(pwd), .o_pstrb(pstrb), .i_pready(prdy), .i_prdata(prd),
        .i_pslverr(perr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is under two hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // Register index to byte address; #1 lets the access edge settle
    task automatic rw(input logic w, input int i, input logic [31:0] d);
        u_host.xfer(w, 12'(i * 4), d, rd, e);
        #1;
    endtask : rw

    function automatic wct_pkg::wct_cfg_t exp_cfg(input int c);
        int b = 'h30 + 4 * c;
        exp_cfg.high_thr = (c == 0) ? ch4_hi : {8'(mdl[b + 1]), 4'(mdl[b] >> 4)};
        exp_cfg.low_thr = {(c == 2) ? ch6_lo : 8'(mdl[b + 3]), 4'(mdl[b + 2] >> 4)};
        exp_cfg.deadband = {(c == 0) ? ch4_db : 4'(mdl[b]), 3'h0};
        exp_cfg.count = 4'(mdl[b + 2]);
    endfunction : exp_cfg

    // n+1 back-to-back samples; flag only after the last, and only if ex
    task automatic evt(input int c, input bit lo, input int n, input logic [11:0] code,
                       input bit ex);
        for (int k = 0; k <= n + 1; k++) begin
            @(posedge clk);
            smp <= '{valid: 1'(k <= n), chan: 3'(c + 4), code: code};
            #1;
            `CHK(lo ? ev_lo[c] : ev_hi[c], 1'(ex && k == n + 1));
        end
        if (ex) stat |= 1 << (c + 3 * lo);
    endtask : evt

    initial begin
        seed = 32'he1a5;
        rst = 1'b1;
        smp = '0;
        ch4_hi = 12'hFFF;
        ch4_db = 4'h0;
        ch6_lo = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 'h32; i <= 'h3A; i++) mdl[i] = (i % 4 == 0) ? 'hF0 : (i % 4 == 1) ? 'hFF : 0;
        for (int i = 'h32; i <= 'h3A; i++) begin
            rw(1'b0, i, 32'h0);
            `CHK(rd, 32'(mdl[i]));
        end
        rw(1'b0, 'h40, 32'h0);
        `CHK(rd, 32'h0);
        @(posedge clk);
        ch4_hi <= 12'($random(seed));
        ch4_db <= 4'($random(seed));
        ch6_lo <= 8'($random(seed));
        for (int i = 'h32; i <= 'h3A; i++) begin
            mdl[i] = $random(seed) & 'hFF;
            rw(1'b1, i, $random(seed) & 32'hFFFF_FF00 | mdl[i]);
        end
        for (int i = 'h32; i <= 'h3A; i++) begin
            rw(1'b0, i, 32'h0);
            `CHK(rd, 32'(mdl[i]));
        end
        for (int c = 0; c < 3; c++) `CHK(cfg[c], exp_cfg(c));
        rw(1'b0, 'h3C, 32'h0);
        `CHK({e, rd}, {1'b1, 32'h0});
        u_host.xfer(1'b1, 12'h0C9, 32'h5A, rd, e);
        `CHK(e, 1'b1);
        rw(1'b0, 'h32, 32'h0);
        `CHK(rd, 32'(mdl['h32]));
        @(posedge clk);
        ch4_hi <= 12'hFFF;
        for (int i = 0; i < wq.size(); i += 2) begin
            mdl[wq[i]] = wq[i + 1];
            rw(1'b1, wq[i], 32'(wq[i + 1]));
        end
        evt(0, 1'b1, 0, 12'h000, 1'b1);
        evt(1, 1'b0, 1, 12'hFFF, 1'b1);
        evt(2, 1'b0, 2, 12'hFFF, 1'b1);
        for (int c = 0; c < 3; c++) `CHK(cfg[c], exp_cfg(c));
        `CHK(irq, 1'b0);
        rw(1'b1, 'h41, 32'h3F);
        `CHK(irq, 1'b1);
        rw(1'b1, 'h40, 32'h0A);
        stat &= ~'h0A;
        rw(1'b0, 'h40, 32'h0);
        `CHK(rd, 32'(stat));
        rw(1'b1, 'h40, 32'h04);
        `CHK({irq, ev_hi, ev_lo}, 7'h00);
        // Tripped high side stays quiet until the code falls past the deadband
        mdl['h34] = 'h02;
        rw(1'b1, 'h34, 32'h02);
        evt(1, 1'b0, 0, 12'h7F8, 1'b0);
        evt(1, 1'b0, 1, 12'hFFF, 1'b0);
        evt(1, 1'b0, 0, 12'h7EF, 1'b0);
        evt(1, 1'b0, 1, 12'hFFF, 1'b1);
        `CHK({irq, ev_hi}, {1'b1, 3'h2});
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rw(1'b0, 'h35, 32'h0);
        `CHK(rd, 32'hFF);
        for (int i = 'h32; i <= 'h3A; i++) mdl[i] = (i % 4 == 0) ? 'hF0 : (i % 4 == 1) ? 'hFF : 0;
        for (int c = 0; c < 3; c++) `CHK(cfg[c], exp_cfg(c));
        `CHK({irq, ev_hi, ev_lo}, 7'h00);
        summarize();
    end
endmodule : window_comparator_threshold_regs_tb_top

`default_nettype wire
